// [pfc_cfg.svh]
// Register offsets, field positions, reset values, length bias and CRC constants.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_OFS_RXBASE 12'h125
`define PFC_OFS_CTRL 12'h126
`define PFC_OFS_MAXLEN 12'h127
`define PFC_OFS_PAYLEN 12'h130
`define PFC_OFS_IRQSTAT 12'h134
`define PFC_OFS_IRQEN 12'h138
`define PFC_OFS_IRQCLR 12'h13C
`define PFC_OFS_FRAME 12'h140
`define PFC_BIT_MSBFIRST 7
`define PFC_BIT_FIXED 6
`define PFC_BIT_CRC 5
`define PFC_MODE_HI 4
`define PFC_MODE_LO 3
`define PFC_OFFSET_HI 2
`define PFC_RST_RXBASE 8'h00
`define PFC_RST_CTRL 8'h00
`define PFC_RST_MAXLEN 8'hF0
`define PFC_LEN_BIAS 9'h004
`define PFC_CRC_INIT 16'hFFFF
`define PFC_CRC_POLY 16'h1021
`endif

// [pfc_pkg.sv]
// Types shared by the frame format block.
package pfc_pkg;
    typedef enum logic [1:0] {
        PFC_DP_PACKET,
        PFC_DP_SPORT_PRE,
        PFC_DP_SPORT_SYNC,
        PFC_DP_UNUSED
    } pfc_dpath_t;
    typedef enum logic [2:0] {
        PFC_RX_IDLE,
        PFC_RX_LEN,
        PFC_RX_BODY,
        PFC_RX_CRC,
        PFC_RX_DONE
    } pfc_rxst_t;
endpackage

// [pfc_bit_order.sv]
// Serialiser and deserialiser for one byte in a chosen bit order.
`include "pfc_cfg.svh"
module pfc_bit_order
    import pfc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic msbFirst,
    input wire logic txLoad,
    input wire logic [7:0] txByte,
    input wire logic txShift,
    output logic txBit,
    input wire logic rxBitValid,
    input wire logic rxBit,
    input wire logic rxClear,
    output logic [7:0] rxByte,
    output logic rxByteValid
);
    logic [7:0] txReg;
    logic [7:0] rxReg;
    logic [2:0] rxCnt;
    logic [7:0] next_rxReg;
    logic [7:0] next_txReg;
    assign txBit = msbFirst ? txReg[7] : txReg[0];
    assign next_txReg = msbFirst ? {txReg[6:0], 1'b0} : {1'b0, txReg[7:1]};
    assign next_rxReg = msbFirst ? {rxReg[6:0], rxBit} : {rxBit, rxReg[7:1]};
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txReg <= 8'h00;
        end else if (txLoad) begin
            txReg <= txByte;
        end else if (txShift) begin
            txReg <= next_txReg;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst || rxClear) begin
            rxReg <= 8'h00;
            rxCnt <= 3'h0;
            rxByteValid <= 1'b0;
        end else begin
            rxByteValid <= rxBitValid && (rxCnt == 3'h7);
            if (rxBitValid) begin
                rxReg <= next_rxReg;
                rxCnt <= rxCnt + 3'h1;
            end
        end
    end
    assign rxByte = rxReg;
endmodule

// [packet_format_control.sv]
// Packet framer: format registers, receive framing, transmit framing.
// Contract
// - Received packet stored from receive base pointer.
// - Bit 7 picks MSB or LSB first.
// - Bit 6 set means fixed length.
// - Bit 6 clear takes length from byte.
// - Bit 5 appends and checks the CRC.
// - Field 4:3 zero packet mode, three unused.
// - Mode one: irq and data at preamble.
// - Mode two: irq at sync, data at preamble.
// - Payload equals length plus offset minus four.
// - Maximum register bounds variable length.
// - Length counts bytes between sync and CRC.
//
// Local design decision: the AHB-Lite interface to the registers.
`include "pfc_cfg.svh"
module packet_format_control
    import pfc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic preambleDet,
    input wire logic syncDet,
    input wire logic frameEnd,
    input wire logic rxBitValid,
    input wire logic rxBit,
    input wire logic txStart,
    input wire logic txBitReq,
    input wire logic [7:0] memRdata,
    output logic [7:0] memAddr,
    output logic [7:0] memWdata,
    output logic memWe,
    output logic txBitOut,
    output logic txActive,
    output logic sportRxData,
    output logic sportRxEn,
    output logic event_output_pin,
    output logic irq
);
    logic [7:0] receive_buffer_base;
    logic [7:0] frame_format_control;
    logic [7:0] maxLen;
    logic [3:0] irqStat;
    logic [3:0] irqEn;
    logic aWr;
    logic [11:0] aAddr;
    pfc_rxst_t rxSt;
    logic [7:0] rxLen;
    logic [7:0] rxCount;
    logic [1:0] crcCnt;
    logic [15:0] rxCrc;
    logic [8:0] payLen;
    logic rxGate;
    logic [8:0] txCount;
    logic [8:0] txTotal;
    logic [2:0] txBitCnt;
    logic txFetch;
    logic [15:0] txCrc;
    logic txInCrc;
    // Decode and field selection.
    wire addrPhase = hsel && hready && htrans[1];
    // Each register is one aligned word: decode the word index.
    wire [11:0] regIdx = haddr[13:2];
    wire wrEn = aWr;
    wire msbFirst = frame_format_control[`PFC_BIT_MSBFIRST];
    wire fixedLen = frame_format_control[`PFC_BIT_FIXED];
    wire crcEn = frame_format_control[`PFC_BIT_CRC];
    wire [1:0] modeBits = frame_format_control[`PFC_MODE_HI:`PFC_MODE_LO];
    wire [2:0] lenOffset = frame_format_control[`PFC_OFFSET_HI:0];
    wire pfc_dpath_t dpath = pfc_dpath_t'(modeBits);
    wire packetMode = (dpath == PFC_DP_PACKET);
    wire sportMode = (dpath == PFC_DP_SPORT_PRE) ||
        (dpath == PFC_DP_SPORT_SYNC);
    wire [7:0] wByte = hwdata[7:0];
    wire [3:0] clrBits = (wrEn && aAddr == `PFC_OFS_IRQCLR) ?
        hwdata[3:0] : 4'h0;
    // Bit order engine.
    logic [7:0] rxByte;
    logic rxByteValid;
    logic txBitW;
    wire rxClear = preambleDet || syncDet;
    wire txLoad = txFetch;
    pfc_bit_order u_order (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .msbFirst(msbFirst),
        .txLoad(txLoad),
        .txByte(txInCrc ? (txCrc[15:8]) : memRdata),
        .txShift(txBitReq && txActive),
        .txBit(txBitW),
        .rxBitValid(rxBitValid && packetMode),
        .rxBit(rxBit),
        .rxClear(rxClear),
        .rxByte(rxByte),
        .rxByteValid(rxByteValid)
    );
    // Length arithmetic: payload = length + offset - 4.
    wire [7:0] lenSrc = fixedLen ? maxLen : rxByte;
    wire [8:0] next_payLen = {1'b0, lenSrc} + {6'h00, lenOffset} -
        `PFC_LEN_BIAS;
    wire overSize = !fixedLen && (rxByte > maxLen);
    wire [7:0] txLenSrc = fixedLen ? maxLen : memRdata;
    wire [8:0] txPay = {1'b0, txLenSrc} + {6'h00, lenOffset} -
        `PFC_LEN_BIAS;
    // CRC-16 over each received or sent byte, MSB of the byte first.
    function automatic logic [15:0] crcByte(input logic [15:0] c,
                                            input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `PFC_CRC_POLY) :
                {r[14:0], 1'b0};
        end
        return r;
    endfunction
    // Bus address phase capture.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            aWr <= 1'b0;
            aAddr <= 12'h000;
        end else if (hready) begin
            aWr <= addrPhase && hwrite;
            aAddr <= regIdx;
        end
    end
    // Register file writes.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            receive_buffer_base <= `PFC_RST_RXBASE;
            frame_format_control <= `PFC_RST_CTRL;
            maxLen <= `PFC_RST_MAXLEN;
            irqEn <= 4'h0;
        end else if (wrEn) begin
            if (aAddr == `PFC_OFS_RXBASE) begin
                receive_buffer_base <= wByte;
            end
            if (aAddr == `PFC_OFS_CTRL) begin
                frame_format_control <= wByte;
            end
            if (aAddr == `PFC_OFS_MAXLEN) begin
                maxLen <= wByte;
            end
            if (aAddr == `PFC_OFS_IRQEN) begin
                irqEn <= hwdata[3:0];
            end
        end
    end
    // Read data: registered for the data phase.
    wire [31:0] rdMux =
        (regIdx == `PFC_OFS_RXBASE) ? {24'h0, receive_buffer_base} :
        (regIdx == `PFC_OFS_CTRL) ? {24'h0, frame_format_control} :
        (regIdx == `PFC_OFS_MAXLEN) ? {24'h0, maxLen} :
        (regIdx == `PFC_OFS_PAYLEN) ? {23'h0, payLen} :
        (regIdx == `PFC_OFS_IRQSTAT) ? {28'h0, irqStat} :
        (regIdx == `PFC_OFS_IRQEN) ? {28'h0, irqEn} :
        (regIdx == `PFC_OFS_FRAME) ? {29'h0, rxSt} : 32'h0;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (addrPhase && !hwrite) begin
            hrdata <= rdMux;
        end
    end
    // Events: 0 preamble (mode 1), 1 sync (mode 2), 2 packet stored,
    // 3 frame end before packet done.
    wire [3:0] evt;
    assign evt[0] = preambleDet && dpath == PFC_DP_SPORT_PRE;
    assign evt[1] = syncDet && dpath == PFC_DP_SPORT_SYNC;
    assign evt[2] = rxSt == PFC_RX_DONE;
    assign evt[3] = packetMode && rxSt != PFC_RX_IDLE &&
        rxSt != PFC_RX_DONE && frameEnd;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_irq
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    irqStat[g] <= 1'b0;
                end else if (evt[g]) begin
                    irqStat[g] <= 1'b1;
                end else if (clrBits[g]) begin
                    irqStat[g] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq <= 1'b0;
            event_output_pin <= 1'b0;
        end else begin
            irq <= |(irqStat & irqEn);
            event_output_pin <= |(irqStat[1:0] & irqEn[1:0]);
        end
    end
    // Serial port streaming: data gate opens at preamble in both modes.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rxGate <= 1'b0;
            sportRxEn <= 1'b0;
            sportRxData <= 1'b0;
        end else begin
            if (!sportMode || frameEnd) begin
                rxGate <= 1'b0;
            end else if (preambleDet) begin
                rxGate <= 1'b1;
            end
            sportRxEn <= rxGate && rxBitValid;
            sportRxData <= rxGate && rxBit;
        end
    end
    // Receive framing: bytes after sync up to the CRC are stored.
    wire rxAbort = frameEnd || !packetMode;
    wire crcOk = !crcEn || rxCrc == 16'h0000;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rxSt <= PFC_RX_IDLE;
            rxLen <= 8'h00;
            rxCount <= 8'h00;
            crcCnt <= 2'h0;
            rxCrc <= `PFC_CRC_INIT;
            payLen <= 9'h000;
            memWe <= 1'b0;
            memAddr <= 8'h00;
            memWdata <= 8'h00;
        end else begin
            memWe <= 1'b0;
            case (rxSt)
                PFC_RX_IDLE: begin
                    if (syncDet && packetMode) begin
                        rxSt <= PFC_RX_LEN;
                        rxCrc <= `PFC_CRC_INIT;
                        rxCount <= 8'h00;
                        crcCnt <= 2'h0;
                    end
                end
                PFC_RX_LEN: begin
                    if (rxAbort) begin
                        rxSt <= PFC_RX_IDLE;
                    end else if (rxByteValid) begin
                        if (overSize) begin
                            rxSt <= PFC_RX_IDLE;
                        end else begin
                            rxLen <= lenSrc;
                            payLen <= next_payLen;
                            rxCrc <= crcByte(rxCrc, rxByte);
                            memWe <= 1'b1;
                            memAddr <= receive_buffer_base;
                            memWdata <= rxByte;
                            rxCount <= 8'h01;
                            rxSt <= (lenSrc <= 8'h01) ?
                                (crcEn ? PFC_RX_CRC : PFC_RX_DONE) :
                                PFC_RX_BODY;
                        end
                    end
                end
                PFC_RX_BODY: begin
                    if (rxAbort) begin
                        rxSt <= PFC_RX_IDLE;
                    end else if (rxByteValid) begin
                        rxCrc <= crcByte(rxCrc, rxByte);
                        memWe <= 1'b1;
                        memAddr <= receive_buffer_base + rxCount;
                        memWdata <= rxByte;
                        rxCount <= rxCount + 8'h01;
                        if (rxCount + 8'h01 >= rxLen) begin
                            rxSt <= crcEn ? PFC_RX_CRC : PFC_RX_DONE;
                        end
                    end
                end
                PFC_RX_CRC: begin
                    if (rxAbort) begin
                        rxSt <= PFC_RX_IDLE;
                    end else if (rxByteValid) begin
                        rxCrc <= crcByte(rxCrc, rxByte);
                        crcCnt <= crcCnt + 2'h1;
                        if (crcCnt == 2'h1) begin
                            rxSt <= PFC_RX_DONE;
                        end
                    end
                end
                PFC_RX_DONE: begin
                    rxSt <= PFC_RX_IDLE;
                end
                default: rxSt <= PFC_RX_IDLE;
            endcase
            if (rxSt == PFC_RX_DONE && !crcOk) begin
                payLen <= 9'h000;
            end
        end
    end
    // Transmit framing: bytes from memory, then CRC when enabled.
    wire txByteDone = txBitReq && txActive && txBitCnt == 3'h7;
    wire txLastData = txCount + 9'h001 >= txTotal;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txActive <= 1'b0;
            txCount <= 9'h000;
            txTotal <= 9'h000;
            txBitCnt <= 3'h0;
            txFetch <= 1'b0;
            txCrc <= `PFC_CRC_INIT;
            txInCrc <= 1'b0;
            txBitOut <= 1'b0;
        end else begin
            txFetch <= 1'b0;
            txBitOut <= txActive ? txBitW : 1'b0;
            if (!txActive) begin
                if (txStart && packetMode) begin
                    txActive <= 1'b1;
                    txFetch <= 1'b1;
                    txCount <= 9'h000;
                    txBitCnt <= 3'h0;
                    txInCrc <= 1'b0;
                    txCrc <= `PFC_CRC_INIT;
                    txTotal <= {1'b0, (fixedLen || memRdata <= maxLen) ?
                        txLenSrc : maxLen};
                end
            end else if (txBitReq) begin
                txBitCnt <= txBitCnt + 3'h1;
                if (txByteDone) begin
                    txFetch <= 1'b1;
                    if (txInCrc) begin
                        txCrc <= {txCrc[7:0], 8'h00};
                        txCount <= txCount + 9'h001;
                        if (txCount[0]) begin
                            txActive <= 1'b0;
                            txFetch <= 1'b0;
                        end
                    end else begin
                        txCrc <= crcByte(txCrc, memRdata);
                        txCount <= txCount + 9'h001;
                        if (txLastData) begin
                            txCount <= 9'h000;
                            txInCrc <= crcEn;
                            txActive <= crcEn;
                            txFetch <= crcEn;
                        end
                    end
                end
            end
        end
    end
endmodule

// [pfc_assertions.sv]
// Concurrent checks on the ports of the frame format block.
`include "pfc_cfg.svh"
module pfc_assertions (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic preambleDet,
    input wire logic syncDet,
    input wire logic frameEnd,
    input wire logic rxBitValid,
    input wire logic memWe,
    input wire logic [7:0] memAddr,
    input wire logic txStart,
    input wire logic txActive,
    input wire logic sportRxEn,
    input wire logic event_output_pin,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wrPend;
    logic firstWr;
    logic gateOn;
    logic [11:0] wrIdx;
    logic [7:0] ctrl;
    logic [7:0] rxBase;
    logic [7:0] irqEn;
    wire [1:0] mode = ctrl[4:3];
    wire wrLand = wrPend && hready;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Shadow copies of the control, receive base and interrupt enable registers, snooped from the bus.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wrPend <= 1'b0;
            firstWr <= 1'b0;
            gateOn <= 1'b0;
            ctrl <= `PFC_RST_CTRL;
            rxBase <= `PFC_RST_RXBASE;
            irqEn <= 8'h00;
        end else begin
            if (hready) begin
                wrPend <= hsel && htrans[1] && hwrite;
                wrIdx <= haddr[13:2];
            end
            if (wrLand && wrIdx == `PFC_OFS_CTRL) ctrl <= hwdata[7:0];
            if (wrLand && wrIdx == `PFC_OFS_RXBASE) rxBase <= hwdata[7:0];
            if (wrLand && wrIdx == `PFC_OFS_IRQEN) irqEn <= hwdata[7:0];
            if (syncDet) firstWr <= 1'b1;
            else if (memWe) firstWr <= 1'b0;
            if (!(mode == 2'h1 || mode == 2'h2) || frameEnd) gateOn <= 1'b0;
            else if (preambleDet) gateOn <= 1'b1;
        end
    end
    sequence preSeen;
        preambleDet && (mode == 2'h1 || mode == 2'h2);
    endsequence
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        sys_rst |=> !irq && !memWe && !txActive && hreadyout)
        else $error("outputs not idle after reset");
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    AST_FIRST_WRITE: assert property (
        memWe && firstWr |-> memAddr == rxBase)
        else $error("first byte not at receive base");
    AST_TX_START: assert property (
        txStart && mode == 2'h0 && !txActive |-> ##[1:2] txActive)
        else $error("transmit did not start");
    AST_STREAM_ON: assert property (gateOn && rxBitValid |=> sportRxEn)
        else $error("stream not gated on at preamble");
    AST_STREAM_OFF: assert property (!gateOn |=> !sportRxEn)
        else $error("stream bit outside the open gate");
    AST_PRE_EVENT: assert property (
        preSeen ##0 (mode == 2'h1 && irqEn[0])
        |-> ##[1:3] event_output_pin && irq)
        else $error("no event on preamble");
    AST_SYNC_EVENT: assert property (
        syncDet && mode == 2'h2 && irqEn[1] |-> ##[1:3] event_output_pin && irq)
        else $error("no event on sync");
    AST_SYNC_ONLY: assert property (
        preambleDet && mode == 2'h2 && !event_output_pin
        |-> ##1 (!event_output_pin)[*2])
        else $error("event raised by preamble");
    AST_PACKET_QUIET: assert property ((mode == 2'h0)[*3] |-> !sportRxEn)
        else $error("stream active in packet mode");
    AST_IRQ_ENABLED: assert property (
        irq |-> irqEn != 8'h00 || $past(irqEn) != 8'h00)
        else $error("interrupt without enable");
endmodule
bind packet_format_control pfc_assertions chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .preambleDet(preambleDet),
    .syncDet(syncDet), .frameEnd(frameEnd), .rxBitValid(rxBitValid),
    .memWe(memWe), .memAddr(memAddr),
    .txStart(txStart), .txActive(txActive), .sportRxEn(sportRxEn),
    .event_output_pin(event_output_pin), .irq(irq));

// [pfc_peer.sv]
// Behavioural model of the far transceiver and its demodulator.
module pfc_peer (
    input wire logic clk_sys,
    output logic preambleDet,
    output logic syncDet,
    output logic frameEnd,
    output logic rxBitValid,
    output logic rxBit,
    output logic txBitReq,
    input wire logic txBitOut
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {preambleDet, syncDet, frameEnd, rxBitValid, rxBit, txBitReq} = '0;
    end
    // One-cycle event pulse; p is frame end, sync, preamble.
    task automatic strobe(input logic [2:0] p);
        @(posedge clk_sys);
        {frameEnd, syncDet, preambleDet} <= p;
        @(posedge clk_sys);
        {frameEnd, syncDet, preambleDet} <= 3'h0;
    endtask
    // The data line flips between strobes so a stale bit is never reused.
    task automatic send_byte(input logic msb, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            rxBitValid <= 1'b1;
            rxBit <= msb ? b[7 - i] : b[i];
            @(posedge clk_sys);
            rxBitValid <= 1'b0;
            rxBit <= ~rxBit;
            @(posedge clk_sys);
        end
    endtask
    task automatic take_byte(input logic msb, output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            txBitReq <= 1'b1;
            @(posedge clk_sys);
            txBitReq <= 1'b0;
            @(posedge clk_sys);
            b[msb ? 7 - i : i] = txBitOut;
        end
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the frame format block.
`include "pfc_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, sys_rst, hsel, hwrite, txStart, hreadyout, hresp;
    logic preambleDet, syncDet, frameEnd, rxBitValid, rxBit, txBitReq;
    logic memWe, txBitOut, txActive, sportRxData, sportRxEn;
    logic event_output_pin, irq;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] memRdata, memAddr, memWdata, v;
    logic [7:0] wrA[$];
    logic [7:0] wrD[$];
    logic sBits[$];
    int errTotal, numChecks, cyc;
    packet_format_control dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .preambleDet(preambleDet),
        .syncDet(syncDet), .frameEnd(frameEnd), .rxBitValid(rxBitValid),
        .rxBit(rxBit), .txStart(txStart), .txBitReq(txBitReq),
        .memRdata(memRdata), .memAddr(memAddr), .memWdata(memWdata),
        .memWe(memWe), .txBitOut(txBitOut), .txActive(txActive),
        .sportRxData(sportRxData), .sportRxEn(sportRxEn),
        .event_output_pin(event_output_pin), .irq(irq));
    pfc_peer peer (.clk_sys(clk_sys), .preambleDet(preambleDet),
        .syncDet(syncDet), .frameEnd(frameEnd), .rxBitValid(rxBitValid),
        .rxBit(rxBit), .txBitReq(txBitReq), .txBitOut(txBitOut));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (memWe === 1'b1) begin
            wrA.push_back(memAddr);
            wrD.push_back(memWdata);
        end
        if (sportRxEn === 1'b1) sBits.push_back(sportRxData);
        cyc++;
        if (cyc > 20000) begin
            errTotal++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("Error %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic bus(input logic s, input logic w, input logic [11:0] idx,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        hsel <= s;
        htrans <= 2'h2;
        haddr <= {18'h0, idx, 2'h0};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1 && n++ < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1 && n++ < 40);
        r = hrdata;
        if (n >= 40) cmp(32'h0, 32'h1, "bus wait");
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        bus(1'b1, 1'b1, idx, {24'h0, d});
    endtask
    task automatic rdc(input logic [11:0] idx, input logic [7:0] m,
                       input logic [7:0] e, input string what);
        bus(1'b1, 1'b0, idx, 32'h0);
        cmp(r & {24'h0, m}, {24'h0, e}, what);
    endtask
    task automatic packet(input logic [7:0] ctl, input logic [7:0] b[$]);
        wr(`PFC_OFS_IRQCLR, 8'h0F);
        wr(`PFC_OFS_CTRL, ctl);
        wrA.delete();
        wrD.delete();
        peer.strobe(3'h1);
        repeat (8) @(posedge clk_sys);
        peer.strobe(3'h2);
        foreach (b[i]) peer.send_byte(ctl[7], b[i]);
        peer.strobe(3'h4);
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic tx_byte(input logic [7:0] d, input logic msb);
        memRdata <= d;
        txStart <= 1'b1;
        @(posedge clk_sys);
        txStart <= 1'b0;
        peer.take_byte(msb, v);
        cmp(v, d, "sent byte");
        cmp(txActive, 1'b0, "one fixed byte");
    endtask
    initial begin
        {sys_rst, hsel, hwrite, txStart} = 4'h8;
        {haddr, hwdata, htrans, memRdata} = '0;
        hsize = 3'h2;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdc(`PFC_OFS_RXBASE, 8'hFF, `PFC_RST_RXBASE, "base reset");
        rdc(`PFC_OFS_CTRL, 8'hFF, `PFC_RST_CTRL, "control reset");
        rdc(`PFC_OFS_MAXLEN, 8'hFF, `PFC_RST_MAXLEN, "max reset");
        wr(12'h3F0, 8'h5A);
        rdc(12'h3F0, 8'hFF, 8'h00, "unmapped read");
        bus(1'b0, 1'b1, `PFC_OFS_MAXLEN, 32'h11);
        rdc(`PFC_OFS_MAXLEN, 8'hFF, `PFC_RST_MAXLEN, "unselected write");
        wr(`PFC_OFS_RXBASE, 8'h40);
        packet(8'h85, '{8'h03, 8'hA5, 8'h3C, 8'h81});
        cmp(wrA[0], 8'h40, "first address");
        cmp(wrD[0], 8'h03, "length byte");
        cmp(wrD[1], 8'hA5, "msb first byte");
        rdc(`PFC_OFS_PAYLEN, 8'hFF, 8'h04, "payload length");
        wr(`PFC_OFS_IRQEN, 8'h04);
        repeat (2) @(posedge clk_sys);
        cmp(irq, 1'b1, "irq on stored packet");
        wr(`PFC_OFS_IRQCLR, 8'h04);
        repeat (2) @(posedge clk_sys);
        cmp(irq, 1'b0, "irq after clear");
        rdc(`PFC_OFS_IRQSTAT, 8'h04, 8'h00, "status cleared");
        wr(`PFC_OFS_RXBASE, 8'h80);
        packet(8'h05, '{8'h03, 8'hA5, 8'h3C, 8'h81});
        cmp(wrA[1], 8'h81, "second address");
        cmp(wrD[1], 8'hA5, "lsb first byte");
        wr(`PFC_OFS_MAXLEN, 8'h02);
        packet(8'h04, '{8'h03, 8'h11, 8'h22, 8'h33});
        rdc(`PFC_OFS_IRQSTAT, 8'h04, 8'h00, "oversize kept");
        cmp(wrA.size(), 0, "oversize discarded");
        packet(8'h47, '{8'h11, 8'h22});
        cmp(wrD[0], 8'h11, "fixed first byte");
        rdc(`PFC_OFS_PAYLEN, 8'hFF, 8'h05, "fixed payload");
        rdc(`PFC_OFS_IRQSTAT, 8'h04, 8'h04, "fixed stored");
        wr(`PFC_OFS_MAXLEN, 8'hF0);
        packet(8'hA4, '{8'h02, 8'h11, 8'h22, 8'h00, 8'h00, 8'h00});
        rdc(`PFC_OFS_PAYLEN, 8'hFF, 8'h00, "bad check word");
        wr(`PFC_OFS_IRQEN, 8'h03);
        for (int m = 0; m < 4; m++) begin
            wr(`PFC_OFS_IRQCLR, 8'h0F);
            wr(`PFC_OFS_CTRL, {3'h0, m[1:0], 3'h0});
            sBits.delete();
            peer.strobe(3'h1);
            peer.send_byte(1'b0, 8'h6B);
            cmp(event_output_pin, m == 1, "preamble event");
            peer.strobe(3'h2);
            repeat (3) @(posedge clk_sys);
            cmp(event_output_pin, m == 1 || m == 2, "sync event");
            cmp(irq, m == 1 || m == 2, "mode irq");
            v = 8'h00;
            foreach (sBits[i]) v = {sBits[i], v[7:1]};
            cmp(sBits.size(), (m == 1 || m == 2) ? 8 : 0, "stream bits");
            cmp(v, (m == 1 || m == 2) ? 8'h6B : 8'h00, "stream data");
            peer.strobe(3'h4);
        end
        wr(`PFC_OFS_MAXLEN, 8'h01);
        wr(`PFC_OFS_CTRL, 8'hC0);
        tx_byte(8'hC3, 1'b1);
        wr(`PFC_OFS_CTRL, 8'h40);
        tx_byte(8'h35, 1'b0);
        give_verdict();
    end
endmodule
